// ===== ifs_top.sv
/*
  Fast and fast-plus SCL high/low count registers, controller enable and
  interrupt mask registers, masked interrupt status, and the SCL timer that
  uses the fast counts, all behind an APB slave.
  Assumes raw interrupt bits, speed mode and run come from the transfer
  engine on the same clock; APB master follows the usual two-phase protocol.
*/
// Our own choice: the APB interface to the registers.
`include "ifs_params.svh"

module ifs_top (
  // clock and reset
  input  wire logic                  CLOCK,
  input  wire logic                  RST_N,
  // apb slave
  input  wire ifs_pkg::ifs_apb_req_t APB_REQ,
  output logic [31:0]                PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  // transfer engine side
  input  wire ifs_pkg::ifs_speed_t   SPEED_MODE,
  input  wire logic                  HS_SPECIAL_TX,
  input  wire logic                  SCL_RUN,
  input  wire logic [15:0]           OTHER_HIGH_COUNT,
  input  wire logic [15:0]           OTHER_LOW_COUNT,
  input  wire logic [13:0]           RAW_IRQ,
  // status to the controller
  output logic                       ENABLE,
  output logic                       FAST_TIMING_SEL,
  output logic                       SCL_LEVEL
);
  import ifs_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  en;
    logic [`IFS_CNT_W-1:0] fast_high;
    logic [`IFS_CNT_W-1:0] fast_low;
    logic [`IFS_IRQ_W-1:0] mask;
    logic [31:0]           rdata;
    logic                  err;
  } ifs_state_t;

  ifs_state_t st;
  ifs_state_t next_st;

  logic                  setup;
  logic                  wr_acc;
  logic                  mapped;
  logic [`IFS_CNT_W-1:0] wr_cnt;
  logic [`IFS_IRQ_W-1:0] masked_irq;
  logic                  fast_sel;
  logic [`IFS_CNT_W-1:0] tmr_high;
  logic [`IFS_CNT_W-1:0] tmr_low;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  assign setup  = APB_REQ.psel && !APB_REQ.penable;
  assign wr_acc = APB_REQ.psel && APB_REQ.penable && APB_REQ.pwrite;
  assign wr_cnt = APB_REQ.pwdata[`IFS_CNT_W-1:0];
  assign masked_irq = RAW_IRQ & st.mask;

  always_comb begin
    case (APB_REQ.paddr)
      `IFS_ADDR_FAST_HIGH, `IFS_ADDR_FAST_LOW, `IFS_ADDR_IRQ_STAT,
      `IFS_ADDR_IRQ_MASK, `IFS_ADDR_ENABLE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    next_st = st;
    // read data is latched in setup so it leaves a flop in the access phase
    if (setup) begin
      next_st.err = !mapped;
      case (APB_REQ.paddr)
        `IFS_ADDR_FAST_HIGH: next_st.rdata = {16'h0000, st.fast_high};
        `IFS_ADDR_FAST_LOW:  next_st.rdata = {16'h0000, st.fast_low};
        `IFS_ADDR_IRQ_STAT:  next_st.rdata = {18'h00000, masked_irq};
        `IFS_ADDR_IRQ_MASK:  next_st.rdata = {18'h00000, st.mask};
        `IFS_ADDR_ENABLE:    next_st.rdata = {31'h00000000, st.en};
        default:             next_st.rdata = 32'h00000000;
      endcase
    end
    if (wr_acc) begin
      case (APB_REQ.paddr)
        `IFS_ADDR_FAST_HIGH: begin
          if (!st.en) begin
            next_st.fast_high = (wr_cnt < `IFS_FAST_HIGH_MIN) ?
                                `IFS_FAST_HIGH_MIN : wr_cnt;
          end
        end
        `IFS_ADDR_FAST_LOW: begin
          if (!st.en) begin
            next_st.fast_low = (wr_cnt < `IFS_FAST_LOW_MIN) ?
                               `IFS_FAST_LOW_MIN : wr_cnt;
          end
        end
        `IFS_ADDR_IRQ_MASK: next_st.mask = APB_REQ.pwdata[`IFS_IRQ_W-1:0];
        `IFS_ADDR_ENABLE:   next_st.en = APB_REQ.pwdata[`IFS_ENABLE_BIT];
        // status is read-only: a write is accepted and dropped
        default: next_st.en = st.en;
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      st <= '{en: 1'b0, fast_high: `IFS_COUNT_RESET, fast_low: `IFS_COUNT_RESET,
              mask: `IFS_MASK_RESET, rdata: 32'h00000000, err: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign PREADY  = 1'b1;
  assign PRDATA  = st.rdata;
  assign PSLVERR = st.err && APB_REQ.psel && APB_REQ.penable;
  assign ENABLE  = st.en;

  // ----------------------------------------------------------------
  // scl timing select
  // ----------------------------------------------------------------
  // a zero fast count before programming still toggles, just too fast
  assign fast_sel = (SPEED_MODE == IFS_SPEED_FAST) ||
                    (SPEED_MODE == IFS_SPEED_HIGH && HS_SPECIAL_TX);
  assign tmr_high = fast_sel ? st.fast_high : OTHER_HIGH_COUNT;
  assign tmr_low  = fast_sel ? st.fast_low  : OTHER_LOW_COUNT;
  assign FAST_TIMING_SEL = fast_sel;

  ifs_scl_timer #(
    .W (`IFS_CNT_W)
  ) u_timer (
    .clk        (CLOCK),
    .rst_n      (RST_N),
    .run        (SCL_RUN),
    .high_count (tmr_high),
    .low_count  (tmr_low),
    .scl_level  (SCL_LEVEL)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);

  a_high_write_kept: assert property (
    wr_acc && APB_REQ.paddr == `IFS_ADDR_FAST_HIGH && !st.en && wr_cnt >= 16'h0006
    |=> st.fast_high == $past(wr_cnt))
    else $error("fast high count not stored");
  a_low_write_kept: assert property (
    wr_acc && APB_REQ.paddr == `IFS_ADDR_FAST_LOW && !st.en && wr_cnt >= 16'h0008
    |=> st.fast_low == $past(wr_cnt))
    else $error("fast low count not stored");
  a_hs_uses_fast: assert property (
    SPEED_MODE == IFS_SPEED_HIGH && HS_SPECIAL_TX
    |-> FAST_TIMING_SEL && tmr_high == st.fast_high && tmr_low == st.fast_low)
    else $error("high-speed special transfer not on fast counts");
  a_enabled_locks: assert property (
    st.en |=> st.fast_high == $past(st.fast_high) && st.fast_low == $past(st.fast_low))
    else $error("fast count changed while enabled");
  a_high_clamp: assert property (
    wr_acc && APB_REQ.paddr == `IFS_ADDR_FAST_HIGH && !st.en && wr_cnt < 16'h0006
    |=> st.fast_high == 16'h0006)
    else $error("fast high count not clamped to 6");
  a_low_clamp: assert property (
    wr_acc && APB_REQ.paddr == `IFS_ADDR_FAST_LOW && !st.en && wr_cnt < 16'h0008
    |=> st.fast_low == 16'h0008)
    else $error("fast low count not clamped to 8");
  a_status_read: assert property (
    setup && APB_REQ.paddr == `IFS_ADDR_IRQ_STAT
    |=> PRDATA[31:14] == 18'h00000 && PRDATA[13:0] == $past(RAW_IRQ & st.mask))
    else $error("status read value wrong");
  a_mask_write: assert property (
    wr_acc && APB_REQ.paddr == `IFS_ADDR_IRQ_MASK
    |=> st.mask == $past(APB_REQ.pwdata[13:0]))
    else $error("mask register not written");
  a_status_ro: assert property (
    wr_acc && APB_REQ.paddr == `IFS_ADDR_IRQ_STAT
    |=> st.mask == $past(st.mask) && st.en == $past(st.en)
        && st.fast_high == $past(st.fast_high) && st.fast_low == $past(st.fast_low))
    else $error("status write changed state");

  c_write_open: cover property (
    wr_acc && APB_REQ.paddr == `IFS_ADDR_FAST_HIGH && !st.en);
  c_write_locked: cover property (
    wr_acc && APB_REQ.paddr == `IFS_ADDR_FAST_LOW && st.en);
  c_hs_special: cover property (
    SPEED_MODE == IFS_SPEED_HIGH && HS_SPECIAL_TX && SCL_RUN);
  c_status_hit: cover property (
    setup && APB_REQ.paddr == `IFS_ADDR_IRQ_STAT && (RAW_IRQ & st.mask) != 14'h0000);

endmodule : ifs_top

// ===== ifs_params.svh
/*
  Offsets, field positions, reset values and limits of the fast SCL timing
  and masked interrupt status block.
  Assumes 32-bit APB data with byte addresses on an 8-bit address bus.
*/
`ifndef IFS_PARAMS_SVH
`define IFS_PARAMS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IFS_ADDR_FAST_HIGH 8'h1c
`define IFS_ADDR_FAST_LOW  8'h20
`define IFS_ADDR_IRQ_STAT  8'h2c
`define IFS_ADDR_IRQ_MASK  8'h30
`define IFS_ADDR_ENABLE    8'h6c

// ----------------------------------------------------------------
// fields, resets and limits
// ----------------------------------------------------------------
`define IFS_CNT_W          16
`define IFS_IRQ_W          14
`define IFS_ENABLE_BIT     0
`define IFS_FAST_HIGH_MIN  16'h0006
`define IFS_FAST_LOW_MIN   16'h0008
`define IFS_COUNT_RESET    16'h0000
`define IFS_MASK_RESET     14'h0000

`endif

// ===== ifs_pkg.sv
/*
  Types shared by the fast SCL timing block and its bench.
  Assumes ifs_params.svh is on the include path.
*/
`include "ifs_params.svh"

package ifs_pkg;

  // ----------------------------------------------------------------
  // bus request carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } ifs_apb_req_t;

  // ----------------------------------------------------------------
  // bus speed of the transfer engine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    IFS_SPEED_STD  = 2'h0,
    IFS_SPEED_FAST = 2'h1,
    IFS_SPEED_HIGH = 2'h3
  } ifs_speed_t;

endpackage : ifs_pkg

// ===== ifs_scl_timer.sv
/*
  SCL period generator: holds SCL high for high_count cycles, then low for
  low_count cycles, while run is high; idles high otherwise.
  Assumes counts and run come from logic on the same clock.
*/
`include "ifs_params.svh"

module ifs_scl_timer #(
  parameter int W = `IFS_CNT_W
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         run,
  input  wire logic [W-1:0] high_count,
  input  wire logic [W-1:0] low_count,
  // line level
  output logic              scl_level
);
  import ifs_pkg::*;

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         level;
  } ifs_tmr_t;

  ifs_tmr_t st;
  ifs_tmr_t next_st;
  logic [W-1:0] limit;

  always_comb begin
    next_st = st;
    limit   = st.level ? high_count : low_count;
    if (!run) begin
      next_st.cnt   = '0;
      next_st.level = 1'b1;
    end else if (st.cnt + W'(1) >= limit) begin
      // >= keeps a zero count from stalling the line
      next_st.cnt   = '0;
      next_st.level = ~st.level;
    end else begin
      next_st.cnt = st.cnt + W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '{cnt: '0, level: 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign scl_level = st.level;

endmodule : ifs_scl_timer

// ===== ifs_scl_monitor.sv
/*
  Partner model on the two-wire side: watches the SCL level and reports
  the length of the last high and the last low phase in clock cycles.
  Assumes SCL is sampled on the same clock as the block.
*/
module ifs_scl_monitor (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // bus line
  input  wire logic scl,
  // measured phases
  output int        hi_len,
  output int        lo_len
);
  int   run;
  logic prev;

  // ----------------------------------------------------------------
  // phase counter
  // ----------------------------------------------------------------
  // a phase is recorded only when it ends, so a stalled line never reports
  always @(posedge clk) begin
    if (!rst_n) begin
      run    <= 0;
      prev   <= 1'b1;
      hi_len <= 0;
      lo_len <= 0;
    end else begin
      if (scl !== prev) begin
        if (prev) hi_len <= run;
        else lo_len <= run;
        run <= 1;
      end else begin
        run <= run + 1;
      end
      prev <= scl;
    end
  end
endmodule : ifs_scl_monitor

// ===== testbench.sv
/*
  Self-checking bench of ifs_top: APB register tasks and SCL phase checks.
  Assumes the package, the parameter header and ifs_scl_monitor.
*/
`include "ifs_params.svh"
`define CHK(nm, ex, gt) begin check_count++; if ((gt) !== (ex)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import ifs_pkg::*;

  logic         clock = 1'b0;
  logic         rst_n = 1'b0;
  ifs_apb_req_t apb_req = '0;
  logic [31:0]  prdata, rdata;
  logic         pready, pslverr, rerr, enable, fsel, scl;
  ifs_speed_t   speed = IFS_SPEED_STD;
  logic         hs_tx = 1'b0;
  logic         scl_run = 1'b0;
  logic [13:0]  raw_irq = 14'h3fff;
  int           hi_len, lo_len;
  int           cycles = 0;
  int           n_errors = 0;
  int           check_count = 0;

  always #50 clock = ~clock;

  ifs_top u_ifs_top (.CLOCK(clock), .RST_N(rst_n), .APB_REQ(apb_req), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SPEED_MODE(speed), .HS_SPECIAL_TX(hs_tx),
    .SCL_RUN(scl_run), .OTHER_HIGH_COUNT(16'h0014), .OTHER_LOW_COUNT(16'h0018),
    .RAW_IRQ(raw_irq), .ENABLE(enable), .FAST_TIMING_SEL(fsel), .SCL_LEVEL(scl));

  ifs_scl_monitor u_ifs_scl_monitor (.clk(clock), .rst_n(rst_n), .scl(scl),
    .hi_len(hi_len), .lo_len(lo_len));

  // ----------------------------------------------------------------
  // verdict and hang guard
  // ----------------------------------------------------------------
  task automatic test_done;
    if (n_errors == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // apb master
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rdata = prdata;
    rerr  = pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask : xfer

  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
    xfer(1'b0, a, 32'h0);
    `CHK(nm, ex, rdata)
  endtask : rd

  // ----------------------------------------------------------------
  // phase table: speed, special transfer, expected high and low
  // ----------------------------------------------------------------
  ifs_speed_t  t_spd[4] = '{IFS_SPEED_FAST, IFS_SPEED_HIGH, IFS_SPEED_HIGH, IFS_SPEED_STD};
  logic        t_hs[4]  = '{1'b0, 1'b1, 1'b0, 1'b0};
  int          t_hi[4]  = '{10, 10, 20, 20};
  int          t_lo[4]  = '{12, 12, 24, 24};

  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    rd(`IFS_ADDR_FAST_HIGH, 32'h0, "high_reset");
    rd(`IFS_ADDR_FAST_LOW, 32'h0, "low_reset");
    rd(`IFS_ADDR_IRQ_STAT, 32'h0, "stat_reset");
    rd(`IFS_ADDR_IRQ_MASK, 32'h0, "mask_reset");
    xfer(1'b1, `IFS_ADDR_FAST_HIGH, 32'h0001_0003);
    rd(`IFS_ADDR_FAST_HIGH, 32'h6, "high_clamp");
    xfer(1'b1, `IFS_ADDR_FAST_LOW, 32'h0000_0002);
    rd(`IFS_ADDR_FAST_LOW, 32'h8, "low_clamp");
    xfer(1'b1, `IFS_ADDR_FAST_HIGH, 32'hffff_abcd);
    rd(`IFS_ADDR_FAST_HIGH, 32'habcd, "high_field");
    xfer(1'b1, `IFS_ADDR_FAST_LOW, 32'h5a5a_1234);
    rd(`IFS_ADDR_FAST_LOW, 32'h1234, "low_field");
    // fast count writes while enabled must bounce
    xfer(1'b1, `IFS_ADDR_ENABLE, 32'h1);
    // the bit lands at the write edge itself, so look one edge later
    @(posedge clock);
    `CHK("enable", 1'b1, enable)
    xfer(1'b1, `IFS_ADDR_FAST_HIGH, 32'ha);
    rd(`IFS_ADDR_FAST_HIGH, 32'habcd, "high_locked");
    xfer(1'b1, `IFS_ADDR_FAST_LOW, 32'hc);
    rd(`IFS_ADDR_FAST_LOW, 32'h1234, "low_locked");
    xfer(1'b1, `IFS_ADDR_ENABLE, 32'h0);
    // counts programmed before the line starts
    xfer(1'b1, `IFS_ADDR_FAST_HIGH, 32'ha);
    xfer(1'b1, `IFS_ADDR_FAST_LOW, 32'hc);
    for (int i = 0; i < 4; i++) begin
      speed   <= t_spd[i];
      hs_tx   <= t_hs[i];
      scl_run <= 1'b1;
      repeat (150) @(posedge clock);
      `CHK("fast_sel", logic'(i < 2), fsel)
      `CHK("scl_high", t_hi[i], hi_len)
      `CHK("scl_low", t_lo[i], lo_len)
      scl_run <= 1'b0;
      repeat (2) @(posedge clock);
    end
    rd(`IFS_ADDR_IRQ_STAT, 32'h0, "stat_masked");
    xfer(1'b1, `IFS_ADDR_IRQ_MASK, 32'hffff_2aaa);
    rd(`IFS_ADDR_IRQ_MASK, 32'h2aaa, "mask");
    rd(`IFS_ADDR_IRQ_STAT, 32'h2aaa, "stat_and");
    xfer(1'b1, `IFS_ADDR_IRQ_STAT, 32'hffff_ffff);
    raw_irq <= 14'h1555;
    rd(`IFS_ADDR_IRQ_STAT, 32'h0, "stat_ro");
    raw_irq <= 14'h2001;
    rd(`IFS_ADDR_IRQ_STAT, 32'h2000, "stat_top");
    rd(8'h04, 32'h0, "unmapped");
    `CHK("slverr", 1'b1, rerr)
    test_done();
  end
endmodule : testbench
